// >>> vec_pkg.sv
// shared constants for the vector element datapath
package vec_pkg;
  localparam int VEC_WIDTH = 128;
  localparam int GPR_WIDTH = 64;
  localparam int IMM_WIDTH = 10;
  localparam int IMM_SIGN_BIT = 9;
  localparam int SHIFT_FIELD_WIDTH = 2;
  localparam int IDX_WIDTH = 4;
  localparam int ADDR_WIDTH = 64;
  localparam int VEC_BYTES = VEC_WIDTH / 8;

  typedef enum logic [1:0] {
    FMT_BYTE = 2'h0,
    FMT_HALF = 2'h1,
    FMT_WORD = 2'h2,
    FMT_DOUBLE = 2'h3
  } element_format_t;

  typedef enum logic [2:0] {
    OP_INTERLEAVE_RIGHT = 3'h0,
    OP_GPR_INSERT = 3'h1,
    OP_ELEMENT_INSERT = 3'h2,
    OP_VECTOR_LOAD = 3'h3,
    OP_IMM_REPLICATE = 3'h4,
    OP_SHIFT_ADD = 3'h5,
    OP_FIXED_MADD = 3'h6,
    OP_FIXED_MADD_ROUND = 3'h7
  } vec_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD_WAIT = 2'h1,
    ST_DONE = 2'h3
  } exec_state_t;
endpackage

// >>> fixed_madd_lane.sv
// one fixed-point multiply-add lane, parameterised by element width
`timescale 1ns/1ps
module fixed_madd_lane #(
  parameter int N = 16
) (
  input wire logic [N-1:0] acc_in,
  input wire logic [N-1:0] src_a_in,
  input wire logic [N-1:0] src_b_in,
  input wire logic round_in,
  output logic [N-1:0] result_out
);
  logic signed [2*N-1:0] product;
  logic signed [2*N:0] acc_wide;
  logic signed [2*N:0] sum;
  logic signed [2*N:0] rounded;
  logic [N:0] top;
  logic pos_ovf;
  logic neg_ovf;

  assign product = $signed(src_a_in) * $signed(src_b_in);
  assign acc_wide = {acc_in[N-1], acc_in[N-1], acc_in, {(N-1){1'b0}}};
  assign sum = acc_wide + {product[2*N-1], product};
  assign rounded = round_in ? sum + ((2*N+1)'(1) <<< (N-2)) : sum;
  assign top = rounded[2*N-1:N-1];
  assign pos_ovf = !top[N] && top[N:N-1] != 2'b00;
  assign neg_ovf = top[N] && top[N:N-1] != 2'b11;
  assign result_out = pos_ovf ? {1'b0, {(N-1){1'b1}}} :
                      neg_ovf ? {1'b1, {(N-1){1'b0}}} : top[N-1:0];
endmodule

// >>> element_lane_ops.sv
// lane-wise interleave, insert and immediate replication for one format
`timescale 1ns/1ps
module element_lane_ops
  import vec_pkg::*;
#(
  parameter int EW = 8,
  parameter int W = 128
) (
  input wire logic [W-1:0] first_src_in,
  input wire logic [W-1:0] second_src_in,
  input wire logic [W-1:0] dest_in,
  input wire logic [EW-1:0] insert_value_in,
  input wire logic [IDX_WIDTH-1:0] index_in,
  input wire logic [IMM_WIDTH-1:0] imm_in,
  output logic [W-1:0] interleave_out,
  output logic [W-1:0] insert_out,
  output logic [W-1:0] replicate_out
);
  localparam int NE = W / EW;
  logic [EW-1:0] imm_ext;

  assign imm_ext = (EW == 8) ? EW'(imm_in[7:0]) :
                   EW'({{(64-IMM_WIDTH){imm_in[IMM_SIGN_BIT]}}, imm_in});

  for (genvar i = 0; i < NE / 2; i++) begin : g_ilv
    assign interleave_out[2*i*EW +: EW] = second_src_in[i*EW +: EW];
    assign interleave_out[(2*i+1)*EW +: EW] = first_src_in[i*EW +: EW];
  end
  for (genvar i = 0; i < NE; i++) begin : g_ins
    assign insert_out[i*EW +: EW] =
      (index_in == IDX_WIDTH'(i)) ? insert_value_in : dest_in[i*EW +: EW];
    assign replicate_out[i*EW +: EW] = imm_ext;
  end
endmodule

// >>> vector_element_unit.sv
// execution datapath for interleave, insert, load, replicate, shift-add, fixed madd
// Behaviour
// - right interleave: even slots from second source low half, odd from first
// - general register insert overwrites only element n with low bits
// - element insert copies source element zero into destination element n
// - vector load fetches full width of bytes from base plus signed offset
// - load offset scaled by element size before adding to base
// - no alignment needed for base or effective address
// - aligned loads are element-atomic, element order free
// - load reports translation faults and address errors plus usual exceptions
// - immediate replicated into every element; bytes use low eight bits
// - wider immediate elements sign-extend from bit nine
// - shift-add: low word shifted by field plus one, added, sign-extended
// - shift-add never raises integer overflow
// - shift-add reserved-instruction unless vector unit present bit is one
// - fixed madd only halfword and word, saturated accumulate
// - product never saturated alone; minus one squared adds exact one
// - multiply and add at double width, truncate last after saturation
// - saturation clamps to largest positive or most negative value
// - rounded variant adds one at top discarded bit before saturation
// - rounded: multiply, add, round wide, then saturate, then truncate
// - non-load ops raise only reserved instruction or unit disabled
`timescale 1ns/1ps
module vector_element_unit
  import vec_pkg::*;
#(
  parameter int W = VEC_WIDTH
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic issue_valid_in,
  input wire logic [2:0] op_in,
  input wire logic [1:0] element_format_in,
  input wire logic [IDX_WIDTH-1:0] index_in,
  input wire logic [IMM_WIDTH-1:0] signed_ten_bit_imm_in,
  input wire logic [SHIFT_FIELD_WIDTH-1:0] shift_amount_field_in,
  input wire logic [W-1:0] dest_vector_in,
  input wire logic [W-1:0] first_source_vector_in,
  input wire logic [W-1:0] second_source_vector_in,
  input wire logic [GPR_WIDTH-1:0] base_gpr_in,
  input wire logic [GPR_WIDTH-1:0] addend_gpr_in,
  input wire logic vector_unit_present_bit_in,
  input wire logic vector_unit_enabled_in,
  input wire logic mem_ready_in,
  input wire logic [W-1:0] mem_data_in,
  input wire logic mem_tlb_fault_in,
  input wire logic mem_addr_error_in,
  output logic issue_ready_out,
  output logic mem_req_out,
  output logic [ADDR_WIDTH-1:0] mem_addr_out,
  output logic [1:0] mem_element_format_out,
  output logic done_out,
  output logic [W-1:0] vector_result_out,
  output logic vector_write_out,
  output logic [GPR_WIDTH-1:0] gpr_result_out,
  output logic gpr_write_out,
  output logic reserved_instr_exc_out,
  output logic unit_disabled_exc_out,
  output logic tlb_fault_exc_out,
  output logic addr_error_exc_out,
  output logic overflow_exc_out
);
  exec_state_t state_q, state_d;
  logic [W-1:0] vec_res_q;
  logic [GPR_WIDTH-1:0] gpr_res_q;
  logic vec_wr_q, gpr_wr_q, ri_q, dis_q, tlb_q, ae_q;
  logic [ADDR_WIDTH-1:0] addr_q;
  logic [1:0] fmt_q;

  logic issue_take, is_load, is_shift_add, is_madd, fmt_illegal;
  logic ri_now, dis_now;
  logic [W-1:0] ilv_b, ilv_h, ilv_w, ilv_d;
  logic [W-1:0] ins_b, ins_h, ins_w, ins_d;
  logic [W-1:0] ve_b, ve_h, ve_w, ve_d;
  logic [W-1:0] rep_b, rep_h, rep_w, rep_d;
  logic [W-1:0] madd_h, madd_w, vec_comb;
  logic [ADDR_WIDTH-1:0] offset_ext, offset_scaled, eff_addr;
  logic [31:0] shifted_word, sum_word;
  logic [GPR_WIDTH-1:0] shift_add_res;

  assign issue_ready_out = (state_q == ST_IDLE);
  assign issue_take = issue_valid_in && issue_ready_out;
  assign is_load = op_in == OP_VECTOR_LOAD;
  assign is_shift_add = op_in == OP_SHIFT_ADD;
  assign is_madd = op_in == OP_FIXED_MADD || op_in == OP_FIXED_MADD_ROUND;
  assign fmt_illegal = is_madd && (element_format_in == FMT_BYTE ||
                                   element_format_in == FMT_DOUBLE);
  assign ri_now = is_shift_add ? !vector_unit_present_bit_in : fmt_illegal;
  // only static exceptions for non-load ops
  assign dis_now = !is_shift_add && !ri_now && !vector_unit_enabled_in;

  // interleave, inserts and immediate per format
  element_lane_ops #(.EW(8), .W(W)) u_ops_b (
    .first_src_in(first_source_vector_in), .second_src_in(second_source_vector_in),
    .dest_in(dest_vector_in), .insert_value_in(base_gpr_in[7:0]),
    .index_in(index_in), .imm_in(signed_ten_bit_imm_in),
    .interleave_out(ilv_b), .insert_out(ins_b), .replicate_out(rep_b));
  element_lane_ops #(.EW(16), .W(W)) u_ops_h (
    .first_src_in(first_source_vector_in), .second_src_in(second_source_vector_in),
    .dest_in(dest_vector_in), .insert_value_in(base_gpr_in[15:0]),
    .index_in(index_in), .imm_in(signed_ten_bit_imm_in),
    .interleave_out(ilv_h), .insert_out(ins_h), .replicate_out(rep_h));
  element_lane_ops #(.EW(32), .W(W)) u_ops_w (
    .first_src_in(first_source_vector_in), .second_src_in(second_source_vector_in),
    .dest_in(dest_vector_in), .insert_value_in(base_gpr_in[31:0]),
    .index_in(index_in), .imm_in(signed_ten_bit_imm_in),
    .interleave_out(ilv_w), .insert_out(ins_w), .replicate_out(rep_w));
  element_lane_ops #(.EW(64), .W(W)) u_ops_d (
    .first_src_in(first_source_vector_in), .second_src_in(second_source_vector_in),
    .dest_in(dest_vector_in), .insert_value_in(base_gpr_in[63:0]),
    .index_in(index_in), .imm_in(signed_ten_bit_imm_in),
    .interleave_out(ilv_d), .insert_out(ins_d), .replicate_out(rep_d));

  // element zero of first source into slot n
  element_lane_ops #(.EW(8), .W(W)) u_ve_b (
    .first_src_in(first_source_vector_in), .second_src_in(second_source_vector_in),
    .dest_in(dest_vector_in), .insert_value_in(first_source_vector_in[7:0]),
    .index_in(index_in), .imm_in(signed_ten_bit_imm_in),
    .interleave_out(), .insert_out(ve_b), .replicate_out());
  element_lane_ops #(.EW(16), .W(W)) u_ve_h (
    .first_src_in(first_source_vector_in), .second_src_in(second_source_vector_in),
    .dest_in(dest_vector_in), .insert_value_in(first_source_vector_in[15:0]),
    .index_in(index_in), .imm_in(signed_ten_bit_imm_in),
    .interleave_out(), .insert_out(ve_h), .replicate_out());
  element_lane_ops #(.EW(32), .W(W)) u_ve_w (
    .first_src_in(first_source_vector_in), .second_src_in(second_source_vector_in),
    .dest_in(dest_vector_in), .insert_value_in(first_source_vector_in[31:0]),
    .index_in(index_in), .imm_in(signed_ten_bit_imm_in),
    .interleave_out(), .insert_out(ve_w), .replicate_out());
  element_lane_ops #(.EW(64), .W(W)) u_ve_d (
    .first_src_in(first_source_vector_in), .second_src_in(second_source_vector_in),
    .dest_in(dest_vector_in), .insert_value_in(first_source_vector_in[63:0]),
    .index_in(index_in), .imm_in(signed_ten_bit_imm_in),
    .interleave_out(), .insert_out(ve_d), .replicate_out());

  for (genvar i = 0; i < W / 16; i++) begin : g_mh
    fixed_madd_lane #(.N(16)) u_lane (
      .acc_in(dest_vector_in[i*16 +: 16]),
      .src_a_in(first_source_vector_in[i*16 +: 16]),
      .src_b_in(second_source_vector_in[i*16 +: 16]),
      .round_in(op_in == OP_FIXED_MADD_ROUND),
      .result_out(madd_h[i*16 +: 16]));
  end
  for (genvar i = 0; i < W / 32; i++) begin : g_mw
    fixed_madd_lane #(.N(32)) u_lane (
      .acc_in(dest_vector_in[i*32 +: 32]),
      .src_a_in(first_source_vector_in[i*32 +: 32]),
      .src_b_in(second_source_vector_in[i*32 +: 32]),
      .round_in(op_in == OP_FIXED_MADD_ROUND),
      .result_out(madd_w[i*32 +: 32]));
  end

  assign offset_ext = {{(ADDR_WIDTH-IMM_WIDTH){signed_ten_bit_imm_in[IMM_SIGN_BIT]}},
                       signed_ten_bit_imm_in};
  assign offset_scaled = offset_ext << element_format_in;
  assign eff_addr = base_gpr_in + offset_scaled;

  // shift by field plus one, wrap to word
  assign shifted_word = base_gpr_in[31:0] << (32'(shift_amount_field_in) + 32'd1);
  assign sum_word = shifted_word + addend_gpr_in[31:0];
  assign shift_add_res = {{32{sum_word[31]}}, sum_word};

  always_comb begin
    vec_comb = dest_vector_in;
    case (op_in)
      OP_INTERLEAVE_RIGHT: begin
        case (element_format_in)
          FMT_BYTE: vec_comb = ilv_b;
          FMT_HALF: vec_comb = ilv_h;
          FMT_WORD: vec_comb = ilv_w;
          default: vec_comb = ilv_d;
        endcase
      end
      OP_GPR_INSERT: begin
        case (element_format_in)
          FMT_BYTE: vec_comb = ins_b;
          FMT_HALF: vec_comb = ins_h;
          FMT_WORD: vec_comb = ins_w;
          default: vec_comb = ins_d;
        endcase
      end
      OP_ELEMENT_INSERT: begin
        case (element_format_in)
          FMT_BYTE: vec_comb = ve_b;
          FMT_HALF: vec_comb = ve_h;
          FMT_WORD: vec_comb = ve_w;
          default: vec_comb = ve_d;
        endcase
      end
      OP_IMM_REPLICATE: begin
        case (element_format_in)
          FMT_BYTE: vec_comb = rep_b;
          FMT_HALF: vec_comb = rep_h;
          FMT_WORD: vec_comb = rep_w;
          default: vec_comb = rep_d;
        endcase
      end
      OP_FIXED_MADD, OP_FIXED_MADD_ROUND: begin
        vec_comb = (element_format_in == FMT_HALF) ? madd_h : madd_w;
      end
      default: vec_comb = dest_vector_in;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (issue_take) begin
          state_d = (is_load && !ri_now && !dis_now) ? ST_LOAD_WAIT : ST_DONE;
        end
      end
      ST_LOAD_WAIT: begin
        if (mem_ready_in) begin
          state_d = ST_DONE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // whole-vector request, atomicity left to memory path
  assign mem_req_out = (state_q == ST_LOAD_WAIT);
  assign mem_addr_out = addr_q;
  assign mem_element_format_out = fmt_q;
  assign done_out = (state_q == ST_DONE);
  assign vector_result_out = vec_res_q;
  assign vector_write_out = vec_wr_q && done_out;
  assign gpr_result_out = gpr_res_q;
  assign gpr_write_out = gpr_wr_q && done_out;
  assign reserved_instr_exc_out = ri_q && done_out;
  assign unit_disabled_exc_out = dis_q && done_out;
  assign tlb_fault_exc_out = tlb_q && done_out;
  assign addr_error_exc_out = ae_q && done_out;
  assign overflow_exc_out = 1'b0;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vec_res_q <= '0;
      gpr_res_q <= '0;
      addr_q <= '0;
      fmt_q <= 2'h0;
    end else if (issue_take) begin
      vec_res_q <= vec_comb;
      gpr_res_q <= shift_add_res;
      addr_q <= eff_addr;
      fmt_q <= element_format_in;
    end else if (state_q == ST_LOAD_WAIT && mem_ready_in) begin
      vec_res_q <= mem_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vec_wr_q <= 1'b0;
      gpr_wr_q <= 1'b0;
      ri_q <= 1'b0;
      dis_q <= 1'b0;
      tlb_q <= 1'b0;
      ae_q <= 1'b0;
    end else if (issue_take) begin
      vec_wr_q <= !is_shift_add && !ri_now && !dis_now;
      gpr_wr_q <= is_shift_add && !ri_now;
      ri_q <= ri_now;
      dis_q <= dis_now;
      tlb_q <= 1'b0;
      ae_q <= 1'b0;
    end else if (state_q == ST_LOAD_WAIT && mem_ready_in) begin
      tlb_q <= mem_tlb_fault_in;
      ae_q <= mem_addr_error_in;
      vec_wr_q <= !mem_tlb_fault_in && !mem_addr_error_in;
    end
  end

  ri_shift_add_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    issue_take && is_shift_add && !vector_unit_present_bit_in
    |=> reserved_instr_exc_out && !gpr_write_out)
    else $error("shift-add without unit not refused");
  shift_add_val_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    issue_take && is_shift_add && vector_unit_present_bit_in
    |=> gpr_write_out && gpr_result_out[63:32] == {32{gpr_result_out[31]}}
    && gpr_result_out[31:0] == ($past(base_gpr_in[31:0]) << ($past(shift_amount_field_in) + 1))
    + $past(addend_gpr_in[31:0]))
    else $error("shift-add result wrong");
  no_overflow_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !overflow_exc_out)
    else $error("overflow raised");
  load_addr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    issue_take && is_load && !ri_now && !dis_now
    |=> mem_req_out && mem_addr_out == $past(base_gpr_in) + $past(offset_scaled))
    else $error("load address wrong");
  load_done_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    mem_req_out && mem_ready_in && !mem_tlb_fault_in && !mem_addr_error_in
    |=> vector_write_out && vector_result_out == $past(mem_data_in))
    else $error("load data not written");
  load_fault_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    mem_req_out && mem_ready_in && mem_tlb_fault_in
    |=> tlb_fault_exc_out && !vector_write_out)
    else $error("tlb fault lost");
  // non-load ops never report address faults
  non_load_exc_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    issue_take && !is_load |=> !tlb_fault_exc_out && !addr_error_exc_out)
    else $error("data fault on non-load");
  madd_fmt_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    issue_take && is_madd && element_format_in == FMT_BYTE
    |=> reserved_instr_exc_out && !vector_write_out)
    else $error("byte madd accepted");
  ilv_byte_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    issue_take && op_in == OP_INTERLEAVE_RIGHT && element_format_in == FMT_BYTE
    && vector_unit_enabled_in
    |=> vector_result_out[15:0] == {$past(first_source_vector_in[7:0]),
                                    $past(second_source_vector_in[7:0])})
    else $error("interleave wrong");
  imm_byte_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    issue_take && op_in == OP_IMM_REPLICATE && element_format_in == FMT_BYTE
    |=> vector_result_out[W-1:W-8] == $past(signed_ten_bit_imm_in[7:0]))
    else $error("immediate not replicated");

  load_cov_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
    mem_req_out ##1 vector_write_out);
  madd_cov_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
    issue_take && op_in == OP_FIXED_MADD_ROUND ##1 vector_write_out);
  sa_cov_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
    gpr_write_out);
endmodule

// >>> mem_partner_model.sv
// memory path model answering vector loads after a chosen latency
`timescale 1ns/1ps
module mem_partner_model
  import vec_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic mem_req_in,
  input wire logic [ADDR_WIDTH-1:0] mem_addr_in,
  input wire logic [3:0] latency_in,
  input wire logic tlb_cfg_in,
  input wire logic aerr_cfg_in,
  output logic mem_ready_out,
  output logic [VEC_WIDTH-1:0] mem_data_out,
  output logic mem_tlb_fault_out,
  output logic mem_addr_error_out
);
  logic [3:0] wait_q;
  logic [3:0] wait_d;
  logic answer;
  assign answer = mem_req_in && !mem_ready_out && (wait_q == latency_in);
  assign wait_d = (mem_req_in && !mem_ready_out) ? wait_q + 4'h1 : 4'h0;
  // any address, whole vector in one beat
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_q <= 4'h0;
      mem_ready_out <= 1'b0;
      mem_data_out <= '0;
      mem_tlb_fault_out <= 1'b0;
      mem_addr_error_out <= 1'b0;
    end else if (answer) begin
      wait_q <= 4'h0;
      mem_ready_out <= 1'b1;
      mem_data_out <= {~mem_addr_in, mem_addr_in};
      mem_tlb_fault_out <= tlb_cfg_in;
      mem_addr_error_out <= aerr_cfg_in;
    end else begin
      wait_q <= wait_d;
      mem_ready_out <= 1'b0;
      mem_data_out <= ~mem_data_out;
      mem_tlb_fault_out <= ~mem_tlb_fault_out;
      mem_addr_error_out <= ~mem_addr_error_out;
    end
  end
endmodule

// >>> vector_element_unit_tb.sv
// self-checking bench for the vector element datapath
`timescale 1ns/1ps
module vector_element_unit_tb;
  import vec_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic vld = 1'b0;
  logic [2:0] op = 3'h0;
  logic [1:0] fmt = 2'h0;
  logic [3:0] idx = 4'h0;
  logic [9:0] imm = 10'h0;
  logic [1:0] sa = 2'h0;
  logic [127:0] dv = '0, fv = '0, sv = '0, vres, mdata;
  logic [63:0] base = '0, add = '0, gres, maddr, addr_seen, ea;
  logic present = 1'b1, enabled = 1'b1, tlb_cfg = 1'b0, aerr_cfg = 1'b0;
  logic [3:0] latency = 4'h0;
  logic rdy, mreq, mrdy, mtlb, maerr, done, vwr, gwr, ri, ud, tlbx, aex, ovf;
  logic [1:0] mfmt;
  logic [6:0] flags;
  int failures = 0, total_checks = 0, f;
  vector_element_unit u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .issue_valid_in(vld),
    .op_in(op), .element_format_in(fmt), .index_in(idx), .signed_ten_bit_imm_in(imm),
    .shift_amount_field_in(sa), .dest_vector_in(dv), .first_source_vector_in(fv),
    .second_source_vector_in(sv), .base_gpr_in(base), .addend_gpr_in(add),
    .vector_unit_present_bit_in(present), .vector_unit_enabled_in(enabled),
    .mem_ready_in(mrdy), .mem_data_in(mdata), .mem_tlb_fault_in(mtlb),
    .mem_addr_error_in(maerr), .issue_ready_out(rdy), .mem_req_out(mreq),
    .mem_addr_out(maddr), .mem_element_format_out(mfmt), .done_out(done),
    .vector_result_out(vres), .vector_write_out(vwr), .gpr_result_out(gres),
    .gpr_write_out(gwr), .reserved_instr_exc_out(ri), .unit_disabled_exc_out(ud),
    .tlb_fault_exc_out(tlbx), .addr_error_exc_out(aex), .overflow_exc_out(ovf));
  mem_partner_model u_mem (.clk_in(clk_in), .resetn_in(resetn_in), .mem_req_in(mreq),
    .mem_addr_in(maddr), .latency_in(latency), .tlb_cfg_in(tlb_cfg), .aerr_cfg_in(aerr_cfg),
    .mem_ready_out(mrdy), .mem_data_out(mdata), .mem_tlb_fault_out(mtlb),
    .mem_addr_error_out(maerr));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bad(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [127:0] got, input logic [127:0] exp);
    bad(got, exp);
  endtask
  task automatic chk_gpr(input logic [63:0] got, input logic [63:0] exp);
    bad({64'h0, got}, {64'h0, exp});
  endtask
  task automatic chk_flags(input logic [6:0] got, input logic [6:0] exp);
    bad({121'h0, got}, {121'h0, exp});
  endtask
  task automatic issue(input logic [2:0] o, input logic [1:0] fm);
    int n;
    logic r;
    op = o;
    fmt = fm;
    vld = 1'b1;
    for (n = 0; n < 40; n++) begin
      r = rdy;
      @(posedge clk_in);
      #1;
      if (r === 1'b1) break;
    end
    vld = 1'b0;
    for (n = 0; n < 40; n++) begin
      if (mreq === 1'b1) addr_seen = maddr;
      if (done === 1'b1) break;
      @(posedge clk_in);
      #1;
    end
    flags = {vwr, gwr, ri, ud, tlbx, aex, ovf};
    if (n == 40) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      stop_test();
    end
    @(posedge clk_in);
    #1;
  endtask
  function automatic logic [127:0] ilv_ref(int f, logic [127:0] a, logic [127:0] b);
    int i, k, ew;
    ew = 8 << f;
    for (i = 0; i < 64 / ew; i++) begin
      for (k = 0; k < ew; k++) begin
        ilv_ref[2*i*ew+k] = b[i*ew+k];
        ilv_ref[(2*i+1)*ew+k] = a[i*ew+k];
      end
    end
  endfunction
  function automatic logic [127:0] ins_ref(int f, logic [127:0] d, logic [63:0] v, int n);
    int k;
    ins_ref = d;
    for (k = 0; k < (8 << f); k++) ins_ref[n*(8<<f)+k] = v[k];
  endfunction
  function automatic logic [127:0] rep_ref(int f, logic [9:0] m);
    logic [63:0] t;
    int j;
    t = {{54{m[9]}}, m};
    for (j = 0; j < 128; j++) rep_ref[j] = t[j % (8 << f)];
  endfunction
  function automatic logic [31:0] qm(int n, logic [31:0] d, logic [31:0] s,
    logic [31:0] t, bit r);
    logic signed [63:0] sd, ss, st, sum, top, mx;
    sd = $signed({d, 32'h0} << (32 - n)) >>> (64 - n);
    ss = $signed({s, 32'h0} << (32 - n)) >>> (64 - n);
    st = $signed({t, 32'h0} << (32 - n)) >>> (64 - n);
    sum = (sd <<< (n - 1)) + ss * st + (r ? (64'sd1 <<< (n - 2)) : 64'sd0);
    top = sum >>> (n - 1);
    mx = (64'sd1 <<< (n - 1)) - 64'sd1;
    qm = (top > mx) ? mx[31:0] : (top < -mx - 64'sd1) ? ~mx[31:0] : top[31:0];
  endfunction
  function automatic logic [127:0] madd_ref(int n, logic [127:0] d, logic [127:0] s,
    logic [127:0] t, bit r);
    logic [31:0] a, b, c, q;
    int i, k;
    for (i = 0; i < 128 / n; i++) begin
      a = '0;
      b = '0;
      c = '0;
      for (k = 0; k < n; k++) {a[k], b[k], c[k]} = {d[i*n+k], s[i*n+k], t[i*n+k]};
      q = qm(n, a, b, c, r);
      for (k = 0; k < n; k++) madd_ref[i*n+k] = q[k];
    end
  endfunction
  initial begin
    repeat (12) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    @(posedge clk_in);
    #1;
    fv = 128'h8000_8000_8000_7fff_8000_0000_4000_c000;
    sv = 128'h8000_8000_4000_7fff_8000_0000_4000_c000;
    dv = 128'h8000_0000_8000_7fff_0000_8000_0001_ffff;
    for (f = 0; f < 4; f++) begin
      issue(OP_INTERLEAVE_RIGHT, f[1:0]);
      chk_vec(vres, ilv_ref(f, fv, sv));
      chk_flags(flags, 7'h40);
      base = 64'h8877_6655_4433_2211;
      idx = 4'((16 >> f) - 1);
      issue(OP_GPR_INSERT, f[1:0]);
      chk_vec(vres, ins_ref(f, dv, base, idx));
      idx = 4'h1;
      issue(OP_ELEMENT_INSERT, f[1:0]);
      chk_vec(vres, ins_ref(f, dv, fv[63:0], 1));
      imm = 10'h2a5;
      issue(OP_IMM_REPLICATE, f[1:0]);
      chk_vec(vres, rep_ref(f, imm));
      base = 64'h1000_0003;
      imm = 10'h3fe;
      latency = 4'(f * 3);
      ea = base + ({{54{imm[9]}}, imm} << f);
      issue(OP_VECTOR_LOAD, f[1:0]);
      chk_gpr(addr_seen, ea);
      chk_vec(vres, {~ea, ea});
      chk_flags(flags, 7'h40);
      chk_flags({5'h0, mfmt}, {5'h0, f[1:0]});
    end
    $display("test lanes and loads done");
    tlb_cfg = 1'b1;
    issue(OP_VECTOR_LOAD, FMT_WORD);
    chk_flags(flags, 7'h04);
    {tlb_cfg, aerr_cfg} = 2'b01;
    issue(OP_VECTOR_LOAD, FMT_HALF);
    chk_flags(flags, 7'h02);
    aerr_cfg = 1'b0;
    $display("test load faults done");
    for (f = 1; f < 3; f++) begin
      issue(OP_FIXED_MADD, f[1:0]);
      chk_vec(vres, madd_ref(8 << f, dv, fv, sv, 1'b0));
      issue(OP_FIXED_MADD_ROUND, f[1:0]);
      chk_vec(vres, madd_ref(8 << f, dv, fv, sv, 1'b1));
    end
    issue(OP_FIXED_MADD, FMT_BYTE);
    chk_flags(flags, 7'h10);
    $display("test fixed madd done");
    base = 64'hffff_0000_c000_0001;
    add = 64'h0000_0000_7fff_ffff;
    for (f = 0; f < 4; f++) begin
      sa = f[1:0];
      issue(OP_SHIFT_ADD, FMT_WORD);
      ea = {32'h0, (base[31:0] << (f + 1)) + add[31:0]};
      chk_gpr(gres, {{32{ea[31]}}, ea[31:0]});
      chk_flags(flags, 7'h20);
    end
    present = 1'b0;
    issue(OP_SHIFT_ADD, FMT_WORD);
    chk_flags(flags, 7'h10);
    present = 1'b1;
    $display("test shift add done");
    enabled = 1'b0;
    issue(OP_INTERLEAVE_RIGHT, FMT_HALF);
    chk_flags(flags, 7'h08);
    issue(OP_VECTOR_LOAD, FMT_BYTE);
    chk_flags(flags, 7'h08);
    $display("test refusals done");
    stop_test();
  end
endmodule
